// *** pkg/sri2c_pkg.sv ***
package sri2c_pkg;

    // target address and high-speed master code pattern
    localparam logic [6:0] TARGET_ADDR   = 7'h48;
    localparam logic [4:0] HS_CODE_UPPER = 5'h01;

    // register offsets
    localparam logic [7:0] OFS_GLOBAL_CONFIG = 8'h09;
    localparam logic [7:0] OFS_INT_FLAGS     = 8'h10;
    localparam logic [7:0] OFS_INT_MASK      = 8'h11;
    localparam logic [7:0] OFS_OUT1_VOLT     = 8'h29;
    localparam logic [7:0] OFS_OUT1_LIMIT    = 8'h2a;
    localparam logic [7:0] OFS_OUT2_VOLT     = 8'h2b;
    localparam logic [7:0] OFS_OUT2_LIMIT    = 8'h2c;
    localparam logic [7:0] OFS_OUT3_VOLT     = 8'h2d;
    localparam logic [7:0] OFS_OUT3_LIMIT    = 8'h2e;

    // reset values
    localparam logic [7:0] RST_GLOBAL_CONFIG = 8'h18;
    localparam logic [7:0] RST_INT_FLAGS     = 8'h00;
    localparam logic [7:0] RST_INT_MASK      = 8'h00;
    localparam logic [7:0] RST_OUT_VOLT      = 8'h10;
    localparam logic [7:0] RST_OUT_LIMIT     = 8'hc6;

    // writable bit masks; unused bits read zero
    localparam logic [7:0] WMASK_GLOBAL_CONFIG = 8'h3f;
    localparam logic [7:0] WMASK_INT           = 8'hbf;
    localparam logic [7:0] WMASK_FULL          = 8'hff;

    // global_config field positions
    localparam int AUTO_RESTART_BIT  = 5;
    localparam int DRIVE_SEL_HI      = 4;
    localparam int DRIVE_SEL_LO      = 3;
    localparam int IDLE_SEL_HI       = 2;
    localparam int IDLE_SEL_LO       = 1;
    localparam int BIAS_OFF_BIT      = 0;

    localparam int NUM_REGS   = 9;
    localparam int FIFO_DEPTH = 8;

    // one register write handed from the link side to the register file
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } sri2c_wr_t;

    // decoded global configuration outputs
    typedef struct packed {
        logic       autoRestart;
        logic [1:0] driveStrength;
        logic [1:0] maxIdleTime;
        logic       biasOff;
    } sri2c_gcfg_t;

endpackage

// *** verilog/sri2c_fifo.sv ***
`timescale 1ns/1ps
module sri2c_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr;
    logic [AW:0]      rdPtr;
    logic             doWrite;
    logic             doRead;

    // full when pointers differ only in the wrap bit
    assign inReady  = !((wrPtr[AW] != rdPtr[AW]) &&
                        (wrPtr[AW-1:0] == rdPtr[AW-1:0]));
    assign outValid = (wrPtr != rdPtr);
    assign outData  = mem[rdPtr[AW-1:0]];
    assign doWrite  = inValid && inReady;
    assign doRead   = outValid && outReady;

    // storage has no reset, contents are don't-care while empty
    always_ff @(posedge core_clk) begin
        if (doWrite) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end

    // pointers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (doWrite) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= rdPtr + 1'b1;
            end
        end
    end
endmodule

// *** verilog/sri2c_regfile.sv ***
`timescale 1ns/1ps
module sri2c_regfile (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    // write stream from the fifo
    input  wire logic                  wrValid,
    output logic                       wrReady,
    input  wire sri2c_pkg::sri2c_wr_t  wrReq,
    // combinational read port
    input  wire logic [7:0]            rdAddr,
    output logic [7:0]                 rdData,
    // configuration state
    output logic [7:0]                 globalConfig
);
    logic [7:0] regs  [sri2c_pkg::NUM_REGS];
    logic [7:0] offs  [sri2c_pkg::NUM_REGS];
    logic [7:0] rsts  [sri2c_pkg::NUM_REGS];
    logic [7:0] masks [sri2c_pkg::NUM_REGS];

    // tables: offset, reset value and writable bits per register
    assign offs  = '{sri2c_pkg::OFS_GLOBAL_CONFIG, sri2c_pkg::OFS_INT_FLAGS,
                     sri2c_pkg::OFS_INT_MASK, sri2c_pkg::OFS_OUT1_VOLT,
                     sri2c_pkg::OFS_OUT1_LIMIT, sri2c_pkg::OFS_OUT2_VOLT,
                     sri2c_pkg::OFS_OUT2_LIMIT, sri2c_pkg::OFS_OUT3_VOLT,
                     sri2c_pkg::OFS_OUT3_LIMIT};
    assign rsts  = '{sri2c_pkg::RST_GLOBAL_CONFIG, sri2c_pkg::RST_INT_FLAGS,
                     sri2c_pkg::RST_INT_MASK, sri2c_pkg::RST_OUT_VOLT,
                     sri2c_pkg::RST_OUT_LIMIT, sri2c_pkg::RST_OUT_VOLT,
                     sri2c_pkg::RST_OUT_LIMIT, sri2c_pkg::RST_OUT_VOLT,
                     sri2c_pkg::RST_OUT_LIMIT};
    assign masks = '{sri2c_pkg::WMASK_GLOBAL_CONFIG, sri2c_pkg::WMASK_INT,
                     sri2c_pkg::WMASK_INT, sri2c_pkg::WMASK_FULL,
                     sri2c_pkg::WMASK_FULL, sri2c_pkg::WMASK_FULL,
                     sri2c_pkg::WMASK_FULL, sri2c_pkg::WMASK_FULL,
                     sri2c_pkg::WMASK_FULL};

    // always drains, one write per cycle
    assign wrReady      = 1'b1;
    assign globalConfig = regs[0];

    // one register per entry; writes to absent offsets are dropped
    for (genvar i = 0; i < sri2c_pkg::NUM_REGS; i++) begin : g_reg
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                regs[i] <= rsts[i];
            end else if (wrValid && wrReq.addr == offs[i]) begin
                regs[i] <= wrReq.data & masks[i];
            end
        end
    end

    // read mux, absent registers read zero
    always_comb begin
        rdData = 8'h00;
        for (int k = 0; k < sri2c_pkg::NUM_REGS; k++) begin
            if (rdAddr == offs[k]) begin
                rdData = regs[k];
            end
        end
    end
endmodule

// *** verilog/sri2c_target.sv ***
`timescale 1ns/1ps
module sri2c_target (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    // serial bus pins
    input  wire logic                   sclIn,
    output logic                        sclOut,
    output logic                        sclOe,
    input  wire logic                   sdaIn,
    output logic                        sdaOut,
    output logic                        sdaOe,
    // regulator controls and status
    output sri2c_pkg::sri2c_gcfg_t      globalCfg,
    output logic                        highSpeedFilter,
    output logic [7:0]                  regPointer
);
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_ADDR  = 7'b0000010,
        ST_ACK   = 7'b0000100,
        ST_PTR   = 7'b0001000,
        ST_WDATA = 7'b0010000,
        ST_RDATA = 7'b0100000,
        ST_MACK  = 7'b1000000
    } sri2c_state_t;

    sri2c_state_t state;
    logic [1:0]  sclSync;
    logic [1:0]  sdaSync;
    logic        sclPrev;
    logic        sdaPrev;
    logic        sclRise;
    logic        sclFall;
    logic        startSeen;
    logic        stopSeen;
    logic [7:0]  shiftReg;
    logic [3:0]  bitCount;
    logic        ackDrive;
    logic        readMode;
    logic        nextPtrPhase;
    logic [7:0]  rdData;
    logic [7:0]  cfgRaw;
    logic        fifoValid;
    logic        fifoReady;
    sri2c_pkg::sri2c_wr_t fifoIn;
    sri2c_pkg::sri2c_wr_t fifoOut;
    logic        fifoOutValid;
    logic        fifoOutReady;

    // two-stage synchronisers on the pins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sclSync <= 2'h3;
            sdaSync <= 2'h3;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclSync <= {sclSync[0], sclIn};
            sdaSync <= {sdaSync[0], sdaIn};
            sclPrev <= sclSync[1];
            sdaPrev <= sdaSync[1];
        end
    end

    // edge and condition detect, on the second stage only
    assign sclRise   = sclSync[1] && !sclPrev;
    assign sclFall   = !sclSync[1] && sclPrev;
    assign startSeen = sclSync[1] && sclPrev && sdaPrev && !sdaSync[1];
    assign stopSeen  = sclSync[1] && sclPrev && !sdaPrev && sdaSync[1];

    // clock line is input only
    always_ff @(posedge core_clk) begin
        sclOut <= 1'b0;
        sclOe  <= 1'b0;
    end

    // protocol state machine; bits sampled on rise, bit 8 is acknowledge
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state        <= ST_IDLE;
            shiftReg     <= 8'h00;
            bitCount     <= 4'h0;
            ackDrive     <= 1'b0;
            readMode     <= 1'b0;
            nextPtrPhase <= 1'b0;
        end else if (startSeen) begin
            // start or repeated start both restart address phase
            state    <= ST_ADDR;
            bitCount <= 4'h0;
            ackDrive <= 1'b0;
        end else if (stopSeen) begin
            state    <= ST_IDLE;
            ackDrive <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    ackDrive <= 1'b0;
                end
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (sclRise && bitCount < 4'h8) begin
                        shiftReg <= {shiftReg[6:0], sdaSync[1]};
                        bitCount <= bitCount + 4'h1;
                    end else if (sclFall && bitCount == 4'h8) begin
                        bitCount <= 4'h0;
                        if (state == ST_ADDR) begin
                            if (shiftReg[7:1] == sri2c_pkg::TARGET_ADDR) begin
                                ackDrive <= 1'b1;
                                readMode <= shiftReg[0];
                                state    <= ST_ACK;
                                nextPtrPhase <= !shiftReg[0];
                            end else begin
                                // foreign address or master code: stay off
                                state <= ST_IDLE;
                            end
                        end else begin
                            ackDrive <= 1'b1;
                            state    <= ST_ACK;
                            nextPtrPhase <= 1'b0;
                        end
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        ackDrive <= 1'b0;
                        if (readMode) begin
                            state <= ST_RDATA;
                        end else if (nextPtrPhase) begin
                            state <= ST_PTR;
                        end else begin
                            state <= ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (sclFall) begin
                        if (bitCount == 4'h7) begin
                            bitCount <= 4'h0;
                            state    <= ST_MACK;
                        end else begin
                            bitCount <= bitCount + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    // ack sampled on rise, next byte only after the fall
                    // so the ninth clock is not counted as a data bit
                    if (sclRise && sdaSync[1]) begin
                        state <= ST_IDLE;
                    end else if (sclFall) begin
                        state <= ST_RDATA;
                    end
                end
            endcase
        end
    end

    // pointer loads from the pointer byte and steps after each written byte and each read byte the master acknowledges
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            regPointer <= 8'h00;
        end else if (!startSeen && !stopSeen && sclFall
                     && bitCount == 4'h8) begin
            if (state == ST_PTR) begin
                regPointer <= shiftReg;
            end else if (state == ST_WDATA) begin
                regPointer <= regPointer + 8'h01;
            end
        end else if (state == ST_MACK && sclRise && !sdaSync[1]
                     && !startSeen && !stopSeen) begin
            regPointer <= regPointer + 8'h01;
        end
    end

    // data line drive: low for acknowledge, or read data bits
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sdaOe <= 1'b0;
        end else if (state == ST_ACK) begin
            sdaOe <= ackDrive;
        end else if (state == ST_RDATA) begin
            sdaOe <= !rdData[3'h7 - bitCount[2:0]];
        end else begin
            sdaOe <= 1'b0;
        end
    end

    // open drain: only ever pull low
    always_ff @(posedge core_clk) begin
        sdaOut <= 1'b0;
    end

    // high-speed filter mode
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            highSpeedFilter <= 1'b0;
        end else if (stopSeen) begin
            highSpeedFilter <= 1'b0;
        end else if (!startSeen && state == ST_ADDR && sclFall
                     && bitCount == 4'h8
                     && shiftReg[7:3] == sri2c_pkg::HS_CODE_UPPER) begin
            highSpeedFilter <= 1'b1;
        end
    end

    // writes are queued, though the register file never stalls them
    assign fifoValid = !startSeen && !stopSeen && state == ST_WDATA
                       && sclFall && bitCount == 4'h8 && fifoReady;
    assign fifoIn    = '{addr: regPointer, data: shiftReg};

    sri2c_fifo #(
        .WIDTH ($bits(sri2c_pkg::sri2c_wr_t)),
        .DEPTH (sri2c_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .inValid  (fifoValid),
        .inReady  (fifoReady),
        .inData   (fifoIn),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOut)
    );

    sri2c_regfile u_regs (
        .core_clk     (core_clk),
        .sys_rst      (sys_rst),
        .wrValid      (fifoOutValid),
        .wrReady      (fifoOutReady),
        .wrReq        (fifoOut),
        .rdAddr       (regPointer),
        .rdData       (rdData),
        .globalConfig (cfgRaw)
    );

    // registered configuration outputs
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            globalCfg <= '{1'b0, 2'h3, 2'h0, 1'b0};
        end else begin
            globalCfg.autoRestart   <= cfgRaw[sri2c_pkg::AUTO_RESTART_BIT];
            globalCfg.driveStrength <=
                cfgRaw[sri2c_pkg::DRIVE_SEL_HI:sri2c_pkg::DRIVE_SEL_LO];
            globalCfg.maxIdleTime   <=
                cfgRaw[sri2c_pkg::IDLE_SEL_HI:sri2c_pkg::IDLE_SEL_LO];
            globalCfg.biasOff       <= cfgRaw[sri2c_pkg::BIAS_OFF_BIT];
        end
    end

    sequence s_stop;
        stopSeen;
    endsequence

    a_scl_never_low: assert property (@(posedge core_clk) disable iff (sys_rst)
        !sclOe) else $error("clock line driven");
    a_stop_filter_off: assert property (@(posedge core_clk)
        disable iff (sys_rst) s_stop |=> !highSpeedFilter)
        else $error("filter not reset by stop");
    a_stop_keep_ptr: assert property (@(posedge core_clk)
        disable iff (sys_rst) s_stop |=> $stable(regPointer))
        else $error("pointer moved on stop");
    a_start_keep_hs: assert property (@(posedge core_clk)
        disable iff (sys_rst) startSeen |=> $stable(highSpeedFilter))
        else $error("restart changed filter");
    a_ptr_step_one: assert property (@(posedge core_clk)
        disable iff (sys_rst) fifoValid |=> regPointer == $past(regPointer)
        + 8'h01) else $error("pointer not stepped");
    a_wr_ack_given: assert property (@(posedge core_clk)
        disable iff (sys_rst) fifoValid |=> ackDrive && state == ST_ACK)
        else $error("data byte not acknowledged");
    a_hs_no_ack: assert property (@(posedge core_clk)
        disable iff (sys_rst) $rose(highSpeedFilter) |-> !ackDrive)
        else $error("master code acknowledged");
    a_reset_cfg: assert property (@(posedge core_clk)
        $fell(sys_rst) |-> globalCfg.driveStrength == 2'h3
        && !globalCfg.autoRestart) else $error("bad config reset");
endmodule

// *** dv/sri2c_master.sv ***
`timescale 1ns/1ps
// bus master partner: pulls the open-drain lines low, pull-ups do the rest
module sri2c_master #(
    parameter int HALF = 4
) (
    // clock for pacing and the resolved data line
    input  wire logic core_clk,
    input  wire logic sdaLine,
    // line pull-downs, 1 = pull low
    output logic      sclPull,
    output logic      sdaPull
);
    // lines released at time zero, the clock stands high outside frames
    initial begin
        sclPull = 1'b0;
        sdaPull = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // start and repeated start look alike
    task automatic start();
        wt(2);
        sdaPull = 1'b0;
        wt(HALF);
        sclPull = 1'b0;
        wt(HALF);
        sdaPull = 1'b1;
        wt(HALF);
        sclPull = 1'b1;
    endtask

    task automatic stop();
        wt(2);
        sdaPull = 1'b1;
        wt(HALF);
        sclPull = 1'b0;
        wt(HALF);
        sdaPull = 1'b0;
        wt(HALF);
    endtask

    // data moves two cycles after the clock falls so it never looks like
    // a start or stop once both lines pass the synchronisers
    task automatic bitx(input logic b, output logic r);
        wt(2);
        sdaPull = ~b;
        wt(HALF - 2);
        sclPull = 1'b0;
        wt(HALF / 2);
        r = sdaLine;
        wt(HALF / 2);
        sclPull = 1'b1;
    endtask

    // one byte msb first plus the ninth bit; mAck = master acknowledge
    task automatic xfer(input logic [7:0] d, input logic mAck,
                        output logic [7:0] q, output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
            q[i] = r;
        end
        bitx(~mAck, r);
        acked = ~r;
    endtask
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic                  core_clk;
    logic                  sys_rst;
    logic                  sclPull;
    logic                  sdaPull;
    wire logic             sclLine;
    wire logic             sdaLine;
    logic                  sclOut;
    logic                  sclOe;
    logic                  sdaOut;
    logic                  sdaOe;
    logic                  highSpeedFilter;
    logic [7:0]            regPointer;
    sri2c_pkg::sri2c_gcfg_t globalCfg;
    int                    miscompares;
    int                    n_compared;
    logic [7:0]            q;
    logic                  ak;
    logic [7:0]            cfgVal [4] = '{8'h00, 8'h0a, 8'h14, 8'hff};

    // wired-and of both parties with pull-ups
    assign sclLine = !(sclPull || (sclOe && !sclOut));
    assign sdaLine = !(sdaPull || (sdaOe && !sdaOut));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    sri2c_target dut (
        .core_clk        (core_clk),
        .sys_rst         (sys_rst),
        .sclIn           (sclLine),
        .sclOut          (sclOut),
        .sclOe           (sclOe),
        .sdaIn           (sdaLine),
        .sdaOut          (sdaOut),
        .sdaOe           (sdaOe),
        .globalCfg       (globalCfg),
        .highSpeedFilter (highSpeedFilter),
        .regPointer      (regPointer)
    );

    sri2c_master mst (
        .core_clk (core_clk),
        .sdaLine  (sdaLine),
        .sclPull  (sclPull),
        .sdaPull  (sdaPull)
    );

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask

    // start or repeated start, then an address byte
    task automatic addr(input logic [7:0] a, input logic exp);
        mst.start();
        mst.xfer(a, 1'b0, q, ak);
        cmp1(ak, exp);
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        addr(8'h90, 1'b1);
        mst.xfer(ptr, 1'b0, q, ak);
        cmp1(ak, 1'b1);
        mst.xfer(d, 1'b0, q, ak);
        cmp1(ak, 1'b1);
        mst.stop();
    endtask

    task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
        addr(8'h90, 1'b1);
        mst.xfer(ptr, 1'b0, q, ak);
        addr(8'h91, 1'b1);
        mst.xfer(8'hff, 1'b0, q, ak);
        cmp8(q, exp);
        mst.stop();
    endtask

    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // a full run needs roughly 6800 cycles
    initial begin
        repeat (40000) @(posedge core_clk);
        miscompares++;
        close_out();
    end

    initial begin
        miscompares = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        repeat (5) @(negedge core_clk);
        cmp1(highSpeedFilter, 1'b0);
        cmp8({2'h0, globalCfg}, 8'h18);
        rd(sri2c_pkg::OFS_GLOBAL_CONFIG, sri2c_pkg::RST_GLOBAL_CONFIG);
        rd(sri2c_pkg::OFS_INT_FLAGS, sri2c_pkg::RST_INT_FLAGS);
        rd(sri2c_pkg::OFS_INT_MASK, sri2c_pkg::RST_INT_MASK);
        // sequential read of the six output registers
        addr(8'h90, 1'b1);
        mst.xfer(8'h29, 1'b0, q, ak);
        addr(8'h91, 1'b1);
        for (int i = 0; i < 6; i++) begin
            mst.xfer(8'hff, i < 5, q, ak);
            cmp8(q, i[0] ? sri2c_pkg::RST_OUT_LIMIT
                         : sri2c_pkg::RST_OUT_VOLT);
        end
        mst.stop();
        cmp8(regPointer, 8'h2e);
        // no pointer byte: the read starts where the last one ended
        addr(8'h91, 1'b1);
        mst.xfer(8'hff, 1'b0, q, ak);
        cmp8(q, sri2c_pkg::RST_OUT_LIMIT);
        mst.stop();
        // every code of every field, reserved bits read back zero
        for (int i = 0; i < 4; i++) begin
            wr(sri2c_pkg::OFS_GLOBAL_CONFIG, cfgVal[i]);
            cmp8({2'h0, globalCfg}, cfgVal[i] & 8'h3f);
            rd(sri2c_pkg::OFS_GLOBAL_CONFIG, cfgVal[i] & 8'h3f);
        end
        // sequential write running past the last register
        addr(8'h90, 1'b1);
        mst.xfer(8'h2b, 1'b0, q, ak);
        for (int i = 0; i < 5; i++) begin
            mst.xfer(8'(8'h11 * (i + 1)), 1'b0, q, ak);
            cmp1(ak, 1'b1);
        end
        mst.stop();
        for (int i = 0; i < 4; i++)
            rd(8'(8'h2b + i), 8'(8'h11 * (i + 1)));
        // pointer outside the map is still acknowledged
        addr(8'h90, 1'b1);
        mst.xfer(8'hff, 1'b0, q, ak);
        cmp1(ak, 1'b1);
        mst.stop();
        // foreign address and general call
        addr(8'h92, 1'b0);
        mst.stop();
        addr(8'h00, 1'b0);
        mst.stop();
        // high-speed master code, then work over a repeated start
        addr(8'h0d, 1'b0);
        cmp1(highSpeedFilter, 1'b1);
        addr(8'h90, 1'b1);
        mst.xfer(sri2c_pkg::OFS_GLOBAL_CONFIG, 1'b0, q, ak);
        addr(8'h91, 1'b1);
        cmp1(highSpeedFilter, 1'b1);
        mst.xfer(8'hff, 1'b0, q, ak);
        cmp8(q, 8'h3f);
        mst.stop();
        repeat (8) @(negedge core_clk);
        cmp1(highSpeedFilter, 1'b0);
        cmp1(sclOe, 1'b0);
        cmp1(sdaOe, 1'b0);
        cmp1(sdaOut, 1'b0);
        cmp1(sclOut, 1'b0);
        close_out();
    end
endmodule
